// ==== pkg/spi_chain_pkg.sv ====
// shared constants and types for the chained spi frame logic
// Notes on behaviour
// - other errors clear on a correct frame
// - error raised in fail safe waits normal mode
// - long frames allowed when byte multiple
// - shift by eight until own address byte
// - copy input to output until last address
// - shift out response high then low byte
// - sixteen bit delay line until select rises
// - error summary shown before first clock
// - status bytes arrive farthest device first
// - response pairs arrive farthest device first
// - frame error shows in next status byte
// - address gap forces output low afterwards
// - address byte needs top bit set
package spi_chain_pkg;
    // frame shape
    localparam int         BYTE_BITS      = 8;
    localparam int         MIN_FRAME_BITS = 24;
    localparam int         CNT_W_DEF      = 10;
    localparam int         RESP_W         = 16;
    localparam int         REG_COUNT      = 32;
    localparam int         REG_ADDR_W     = 5;
    localparam logic [2:0] BYTE_END       = 3'h7;
    // address byte fields
    localparam int         ADDR_MARK_BIT  = 7;
    localparam int         LAST_MARK_BIT  = 6;
    localparam int         OP_BIT         = 0;
    localparam logic [4:0] ID_REG_ADDR    = 5'h1f;
    // status byte layout and reset
    localparam int         ERR_W          = 6;
    localparam int         STAT_SUM_BIT   = 7;
    localparam logic [7:0] STAT_RST       = 8'h80;
    // link phases within a frame
    typedef enum logic [1:0] {
        PH_HUNT,
        PH_PASS,
        PH_RESP,
        PH_MUTE
    } phase_t;
endpackage : spi_chain_pkg

// ==== pkg/frame_judge_if.sv ====
// carrier between frame bookkeeping and the frame judge
`timescale 1ns/1ps
interface frame_judge_if #(
    parameter int CNT_W = 10
);
    logic [CNT_W-1:0] bit_count;  // edges counted in the frame
    logic             clocked;    // at least one clock edge seen
    logic             addr_seen;  // own address byte captured
    logic             last_seen;  // last address byte seen
    logic             gap;        // non-address byte between addresses
    logic             fail_safe;  // device in fail safe mode
    logic [7:0]       own_addr;   // captured own address byte
    logic             err;        // frame is a protocol error
    logic             exec;       // frame may be executed
    modport judge (
        input  bit_count, clocked, addr_seen, last_seen, gap,
        input  fail_safe, own_addr,
        output err, exec
    );
    modport owner (
        output bit_count, clocked, addr_seen, last_seen, gap,
        output fail_safe, own_addr,
        input  err, exec
    );
endinterface : frame_judge_if

// ==== core/bit_sync.sv ====
// two flip-flop synchroniser for level signals
`timescale 1ns/1ps
module bit_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input  wire logic         clock_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;  // first stage, read only by s2
        logic [W-1:0] s2;  // settled stage
    } sync_t;
    sync_t st_q;
    sync_t st_d;

    // shift through both stages
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = d_in;
        st_d.s2 = st_q.s1;
    end

    // registered copy with synchronous reset
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            st_q <= {RST_VAL, RST_VAL};
        else
            st_q <= st_d;
    end

    assign q_out = st_q.s2;
endmodule : bit_sync

// ==== core/frame_judge.sv ====
// judges a finished frame: protocol error or executable command
`timescale 1ns/1ps
module frame_judge #(
    parameter int CNT_W = 10
)(
    frame_judge_if.judge jf
);
    logic len_bad;  // too short or not whole bytes
    logic id_clr;   // clear command to the identity register
    logic fs_wr;    // write or clear while in fail safe

    // combinational verdict on the captured frame
    always_comb
    begin
        len_bad = (jf.bit_count < CNT_W'(spi_chain_pkg::MIN_FRAME_BITS))
                || (jf.bit_count[2:0] != 3'h0);
        id_clr  = jf.own_addr[spi_chain_pkg::OP_BIT]
                && (jf.own_addr[spi_chain_pkg::REG_ADDR_W-1:0]
                    == spi_chain_pkg::ID_REG_ADDR);
        fs_wr   = jf.fail_safe && jf.own_addr[spi_chain_pkg::OP_BIT];
        jf.err  = jf.clocked && (len_bad || !jf.addr_seen
                || !jf.last_seen || jf.gap || id_clr || fs_wr);
        jf.exec = jf.clocked && !jf.err;
    end
endmodule : frame_judge

// ==== core/spi_chain_top.sv ====
// chained spi target: link shifter, frame bookkeeping, error flag
`timescale 1ns/1ps
module spi_chain_top #(
    parameter int CNT_W = spi_chain_pkg::CNT_W_DEF  // frame counter width
)(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        chip_select_low_in,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    input  wire logic        fail_safe_in,
    input  wire logic        pwm_overlap_error_bit_in,
    input  wire logic [5:0]  error_bits_in,
    input  wire logic        resp_wr_in,
    input  wire logic [4:0]  resp_addr_in,
    input  wire logic [15:0] resp_data_in,
    output logic             cmd_valid_out,
    output logic [7:0]       cmd_addr_out,
    output logic [15:0]      cmd_data_out,
    output logic             protocol_error_flag_out,
    output logic             global_error_summary_out,
    output logic [7:0]       chained_status_byte_out
);
    // ------------------------------------------------------------
    // parameter checks and local sizes
    // ------------------------------------------------------------
    localparam int RW = spi_chain_pkg::RESP_W;
    localparam int AW = spi_chain_pkg::REG_ADDR_W;

    // counter must reach the shortest legal frame
    generate
        if (CNT_W < 5)
        begin : g_bad_cnt
            $error("counter too narrow for a frame");
        end
    endgenerate

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    // link side state, clocked by the controller's clock
    typedef struct packed {
        spi_chain_pkg::phase_t phase;     // position within frame
        logic [CNT_W-1:0]      cnt;       // rising edges this frame
        logic [RW-1:0]         tx;        // output delay line
        logic [RW-1:0]         rx;        // last bits received
        logic [7:0]            own_addr;  // own address byte
        logic                  addr_seen; // own address captured
        logic                  last_seen; // last address detected
        logic                  gap;       // address run broken
    } link_t;

    // system side state, clocked by clock_in
    typedef struct packed {
        logic        cs_prev;    // select level one cycle ago
        logic        sck_prev;   // clock level one cycle ago
        logic        clocked;    // edges seen in this frame
        logic        pol_err;    // clock high at select fall
        logic        proto_err;  // frame-caused error latch
        logic        err_in_fs;  // latch raised in fail safe
        logic        flag;       // protocol error flag
        logic [7:0]  stat;       // status byte for next frame
        logic        cmd_valid;  // command strobe
        logic [7:0]  cmd_addr;   // executed address byte
        logic [15:0] cmd_data;   // executed data word
    } sys_t;

    localparam sys_t SYS_RST = '{
        cs_prev:   1'b1,
        sck_prev:  1'b0,
        clocked:   1'b0,
        pol_err:   1'b0,
        proto_err: 1'b0,
        err_in_fs: 1'b0,
        flag:      1'b0,
        stat:      spi_chain_pkg::STAT_RST,
        cmd_valid: 1'b0,
        cmd_addr:  8'h00,
        cmd_data:  16'h0000
    };

    link_t         ln_q;          // link state
    link_t         ln_d;          // link next state
    sys_t          sy_q;          // system state
    sys_t          sy_d;          // system next state
    logic          started_q;     // first edge of frame passed
    logic          sdo_fall_q;    // output bit set on falling edge
    logic          cs_s;          // synchronised select level
    logic          sck_s;         // synchronised clock level
    logic          cs_fall;       // select went low
    logic          frame_end;     // select went high
    logic          frame_err;     // finished frame is faulty
    logic [7:0]    byte_in;       // byte completing at this edge
    logic          byte_done;     // this edge ends a byte
    logic [RW-1:0] resp_mem [spi_chain_pkg::REG_COUNT]; // responses

    // ------------------------------------------------------------
    // response store
    // ------------------------------------------------------------
    // written by the register logic outside; read by the link while
    // stable, so writes should not land during an address byte
    always_ff @(posedge clock_in)
    begin
        if (resp_wr_in)
            resp_mem[resp_addr_in] <= resp_data_in;
    end

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    // frame start marker, cleared by the frame's own select
    always_ff @(posedge sclk_in or posedge chip_select_low_in)
    begin
        if (chip_select_low_in)
            started_q <= 1'b0;
        else
            started_q <= 1'b1;
    end

    assign byte_in   = {ln_q.rx[6:0], sdi_in};
    assign byte_done = started_q
                    && (ln_q.cnt[2:0] == spi_chain_pkg::BYTE_END);

    // next link state on each rising edge
    always_comb
    begin
        ln_d = ln_q;
        if (!started_q)
        begin
            // first edge: status byte enters the eight bit line
            ln_d           = '0;
            ln_d.phase     = spi_chain_pkg::PH_HUNT;
            ln_d.cnt       = CNT_W'(1);
            ln_d.rx        = {15'h0000, sdi_in};
            ln_d.tx        = {8'h00, sy_q.stat[6:0], sdi_in};
        end
        else
        begin
            if (ln_q.cnt != '1)
                ln_d.cnt = ln_q.cnt + 1'b1;
            ln_d.rx = {ln_q.rx[RW-2:0], sdi_in};
            ln_d.tx = {ln_q.tx[RW-2:0], sdi_in};
            if (byte_done)
            begin
                case (ln_q.phase)
                    spi_chain_pkg::PH_HUNT:
                    begin
                        if (byte_in[spi_chain_pkg::ADDR_MARK_BIT])
                        begin
                            ln_d.own_addr  = byte_in;
                            ln_d.addr_seen = 1'b1;
                            if (byte_in[spi_chain_pkg::LAST_MARK_BIT])
                            begin
                                ln_d.last_seen = 1'b1;
                                ln_d.phase     = spi_chain_pkg::PH_RESP;
                                ln_d.tx        = resp_mem[byte_in[AW-1:0]];
                            end
                            else
                            begin
                                ln_d.phase = spi_chain_pkg::PH_PASS;
                            end
                        end
                    end
                    spi_chain_pkg::PH_PASS:
                    begin
                        if (!byte_in[spi_chain_pkg::ADDR_MARK_BIT])
                        begin
                            ln_d.gap   = 1'b1;
                            ln_d.phase = spi_chain_pkg::PH_MUTE;
                        end
                        else if (byte_in[spi_chain_pkg::LAST_MARK_BIT])
                        begin
                            ln_d.last_seen = 1'b1;
                            ln_d.phase     = spi_chain_pkg::PH_RESP;
                            ln_d.tx        = resp_mem[ln_q.own_addr[AW-1:0]];
                        end
                    end
                    default:
                    begin
                        // response and mute phases just keep shifting
                    end
                endcase
            end
        end
    end

    // link state register; no reset, the first edge reloads it
    always_ff @(posedge sclk_in)
    begin
        ln_q <= ln_d;
    end

    always_ff @(negedge sclk_in)
    begin
        if (ln_q.phase == spi_chain_pkg::PH_RESP)
            sdo_fall_q <= ln_q.tx[RW-1];
        else
            sdo_fall_q <= ln_q.tx[7];
    end

    // pin mux: summary before first edge, then phase source
    always_comb
    begin
        if (chip_select_low_in)
            sdo_out = 1'b0;
        else if (!started_q)
            sdo_out = sy_q.stat[spi_chain_pkg::STAT_SUM_BIT];
        else if (ln_q.phase == spi_chain_pkg::PH_PASS)
            sdo_out = sdi_in;
        else if (ln_q.phase == spi_chain_pkg::PH_MUTE)
            sdo_out = 1'b0;
        else
            sdo_out = sdo_fall_q;
    end

    // pin driven only while selected
    assign sdo_oe_out = !chip_select_low_in;

    // ------------------------------------------------------------
    // crossings into the system domain
    // ------------------------------------------------------------
    bit_sync #(
        .W       (2),
        .RST_VAL (2'b10)
    ) u_pin_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .d_in     ({chip_select_low_in, sclk_in}),
        .q_out    ({cs_s, sck_s})
    );

    assign cs_fall   = sy_q.cs_prev && !cs_s;
    assign frame_end = !sy_q.cs_prev && cs_s;

    // ------------------------------------------------------------
    // frame judgement
    // ------------------------------------------------------------
    frame_judge_if #(.CNT_W(CNT_W)) jf ();

    // link results are still while select is high
    assign jf.bit_count = ln_q.cnt;
    assign jf.clocked   = sy_q.clocked;
    assign jf.addr_seen = ln_q.addr_seen;
    assign jf.last_seen = ln_q.last_seen;
    assign jf.gap       = ln_q.gap;
    assign jf.fail_safe = fail_safe_in;
    assign jf.own_addr  = ln_q.own_addr;

    frame_judge #(
        .CNT_W (CNT_W)
    ) u_judge (
        .jf (jf.judge)
    );

    // clock high at either select edge is a polarity error
    assign frame_err = jf.err || sy_q.pol_err || sck_s;

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    // bookkeeping, error latch and status byte
    always_comb
    begin
        sy_d           = sy_q;
        sy_d.cmd_valid = 1'b0;
        sy_d.cs_prev   = cs_s;
        sy_d.sck_prev  = sck_s;
        // any rising clock while selected
        if (!cs_s && sck_s && !sy_q.sck_prev)
            sy_d.clocked = 1'b1;
        // new frame: clear per-frame notes
        if (cs_fall)
        begin
            sy_d.clocked = 1'b0;
            sy_d.pol_err = sck_s;
        end
        if (!fail_safe_in)
            sy_d.err_in_fs = 1'b0;
        if (frame_end)
        begin
            if (frame_err)
            begin
                sy_d.proto_err = 1'b1;
                if (fail_safe_in)
                    sy_d.err_in_fs = 1'b1;
            end
            else if (jf.exec)
            begin
                sy_d.cmd_valid = 1'b1;
                sy_d.cmd_addr  = ln_q.own_addr;
                sy_d.cmd_data  = ln_q.rx;
                if (!(sy_q.err_in_fs && fail_safe_in))
                    sy_d.proto_err = 1'b0;
            end
        end
        // overlap error held by its bit
        sy_d.flag = sy_d.proto_err || pwm_overlap_error_bit_in;
        // status frozen while a frame runs
        if (cs_s)
            sy_d.stat = {(|error_bits_in) || sy_d.flag,
                         error_bits_in, sy_d.flag};
    end

    // system state register
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            sy_q <= SYS_RST;
        else
            sy_q <= sy_d;
    end

    assign cmd_valid_out            = sy_q.cmd_valid;
    assign cmd_addr_out             = sy_q.cmd_addr;
    assign cmd_data_out             = sy_q.cmd_data;
    assign protocol_error_flag_out  = sy_q.flag;
    assign global_error_summary_out = sy_q.stat[spi_chain_pkg::STAT_SUM_BIT];
    assign chained_status_byte_out  = sy_q.stat;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int MINB = spi_chain_pkg::MIN_FRAME_BITS;

    property p_overlap_holds;
        @(posedge clock_in) disable iff (rst_in)
        pwm_overlap_error_bit_in |=> protocol_error_flag_out;
    endproperty
    a_overlap_holds: assert property (p_overlap_holds)
        else $error("overlap error did not hold the flag");

    property p_clean_clears;
        @(posedge clock_in) disable iff (rst_in)
        (frame_end && !frame_err && jf.exec && !fail_safe_in
         && !pwm_overlap_error_bit_in) |=> !protocol_error_flag_out;
    endproperty
    a_clean_clears: assert property (p_clean_clears)
        else $error("correct frame left the flag set");

    property p_fs_hold;
        @(posedge clock_in) disable iff (rst_in)
        (frame_end && fail_safe_in && sy_q.err_in_fs)
            |=> sy_q.proto_err;
    endproperty
    a_fs_hold: assert property (p_fs_hold)
        else $error("fail safe error cleared too early");

    property p_short_frame;
        @(posedge clock_in) disable iff (rst_in)
        (frame_end && sy_q.clocked && ln_q.cnt < CNT_W'(MINB))
            |=> sy_q.proto_err && !cmd_valid_out;
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("short frame not flagged");

    property p_error_next_status;
        @(posedge clock_in) disable iff (rst_in)
        (frame_end && frame_err) |=> chained_status_byte_out[0]
            && global_error_summary_out;
    endproperty
    a_error_next_status: assert property (p_error_next_status)
        else $error("frame error missing from status");

    property p_exec_word;
        @(posedge clock_in) disable iff (rst_in)
        (frame_end && !frame_err && jf.exec) |=> cmd_valid_out
            && cmd_data_out == $past(ln_q.rx) ##1 !cmd_valid_out;
    endproperty
    a_exec_word: assert property (p_exec_word)
        else $error("command not executed with frame data");

    property p_non_address;
        @(posedge sclk_in) disable iff (chip_select_low_in)
        (byte_done && ln_q.phase == spi_chain_pkg::PH_HUNT && !ln_q.rx[6])
            |=> ln_q.phase == spi_chain_pkg::PH_HUNT;
    endproperty
    a_non_address: assert property (p_non_address)
        else $error("byte without top bit taken as address");

    property p_own_addr;
        @(posedge sclk_in) disable iff (chip_select_low_in)
        (byte_done && ln_q.phase == spi_chain_pkg::PH_HUNT && ln_q.rx[6])
            |=> ln_q.addr_seen && ln_q.own_addr == $past(byte_in);
    endproperty
    a_own_addr: assert property (p_own_addr)
        else $error("own address byte not captured");

    property p_mute;
        @(posedge sclk_in) disable iff (chip_select_low_in)
        (started_q && ln_q.phase == spi_chain_pkg::PH_MUTE)
            |-> !sdo_out ##1 ln_q.phase == spi_chain_pkg::PH_MUTE;
    endproperty
    a_mute: assert property (p_mute)
        else $error("output not held low after address gap");

    property p_summary_first;
        @(posedge sclk_in) disable iff (chip_select_low_in)
        !started_q |-> sdo_out == sy_q.stat[7];
    endproperty
    a_summary_first: assert property (p_summary_first)
        else $error("summary bit missing before first clock");

    property p_resp_load;
        @(posedge sclk_in) disable iff (chip_select_low_in)
        (byte_done && ln_q.phase == spi_chain_pkg::PH_PASS
         && byte_in[7] && byte_in[6])
            |=> ln_q.tx == resp_mem[ln_q.own_addr[AW-1:0]];
    endproperty
    a_resp_load: assert property (p_resp_load)
        else $error("response word not loaded after last address");
endmodule : spi_chain_top

// ==== tb/spi_ctrl_model.sv ====
// spi controller model for the link side of the chain
`timescale 1ns/1ps
module spi_ctrl_model (
    output logic      sclk_out,
    output logic      cs_low_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    // idle: clock low, deselected, data at its pull-down level
    initial
    begin
        sclk_out = 1'b0;
        cs_low_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic frame(input logic [63:0] tx, input int n,
                         output logic [63:0] rx);
        rx = '0;
        cs_low_out = 1'b0;
        #48;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi_out = tx[i];
            #24 rx = {rx[62:0], miso_in};
            sclk_out = 1'b1;
            #24 sclk_out = 1'b0;
        end
        #48 cs_low_out = 1'b1;
        mosi_out = 1'b0;
    endtask : frame
endmodule : spi_ctrl_model

// ==== tb/spi_daisy_chain_frame_logic_tb.sv ====
// self-checking bench for the chained spi frame logic
`timescale 1ns/1ps
module spi_daisy_chain_frame_logic_tb;
    logic        clock_in, rst_in, sclk, csl, sdi, sdo, oe, fs, pwm, wr;
    logic        cv, flag, gsum, lat, lat_fs;
    logic [5:0]  eb;
    logic [4:0]  wa;
    logic [15:0] wd, cdat, resp_m [32];
    logic [7:0]  cadr, stb;
    int          n_fail, checked, n_cmd;
    spi_chain_top spi_chain_top_inst (.clock_in, .rst_in, .sclk_in(sclk),
        .chip_select_low_in(csl), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_out(oe), .fail_safe_in(fs), .pwm_overlap_error_bit_in(pwm),
        .error_bits_in(eb), .resp_wr_in(wr), .resp_addr_in(wa),
        .resp_data_in(wd), .cmd_valid_out(cv), .cmd_addr_out(cadr),
        .cmd_data_out(cdat), .protocol_error_flag_out(flag),
        .global_error_summary_out(gsum), .chained_status_byte_out(stb));
    spi_ctrl_model spi_ctrl_model_inst (.sclk_out(sclk), .cs_low_out(csl),
        .mosi_out(sdi), .miso_in(sdo));
    // system clock, and a count of command pulses
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) if (cv === 1'b1) n_cmd++;
    // compare a port value, then a serial word seen by the controller
    task automatic chk_port(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t port %0h exp %0h", $time, got, exp);
        end
    endtask : chk_port
    task automatic chk_link(input logic [47:0] got, input logic [47:0] exp);
        chk_port(got, exp);
    endtask : chk_link
    // model status byte: summary held by a nonzero cause, flag in bit 0
    function automatic logic [7:0] stat();
        return {1'b1, eb, lat | pwm};
    endfunction : stat
    // one frame, then command count, flag model and status compare
    task automatic run(input logic [63:0] tx, input int n, input bit good,
                       input logic [47:0] exp);
        logic [63:0] rx;
        int          c0;
        c0 = n_cmd;
        spi_ctrl_model_inst.frame(tx, n, rx);
        chk_link(rx[47:0], exp);
        repeat (10) @(posedge clock_in);
        chk_port(48'(n_cmd - c0), 48'(good));
        if (!good)
        begin
            lat = 1'b1;
            lat_fs = fs;
        end
        else if (!(lat_fs && fs))
            lat = 1'b0;
        chk_port(flag, lat | pwm);
        chk_port(stb, stat());
        chk_port(gsum, 1'b1);
    endtask : run
    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        run({a, d}, 24, 1, {stat(), resp_m[a[4:0]]});
        chk_port({cadr, cdat}, {a, d});
    endtask : rd
    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    // watchdog well beyond the expected run time
    initial
    begin
        #300us;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        logic [7:0]  a;
        logic [15:0] d, e;
        void'($urandom(93628));
        {rst_in, fs, pwm, wr, wa, wd, lat, lat_fs} = '0;
        rst_in = 1'b1;
        eb = 6'h00;
        repeat (16) @(posedge clock_in);
        chk_port(stb, 8'h80);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk_port(oe, 1'b0);
        eb <= 6'($urandom) | 6'h01;
        for (int i = 0; i < 32; i++)
        begin
            d = $urandom;
            resp_m[i] = d;
            wr <= 1'b1;
            wa <= i[4:0];
            wd <= d;
            @(posedge clock_in);
        end
        wr <= 1'b0;
        repeat (15000) @(posedge clock_in);
        for (int i = 0; i < 3; i++)
            rd(8'hc0 | (8'($urandom) & 8'h1e), 16'($urandom));
        a = 8'h80 | (8'($urandom) & 8'h1e);
        d = $urandom;
        e = $urandom;
        run({a, 8'hc2, e, d}, 48, 1, {stat(), 8'hc2, resp_m[a[4:0]], e});
        chk_port({cadr, cdat}, {a, d});
        run({a | 8'h40, 12'h5a5}, 20, 0, {stat(), resp_m[a[4:0]][15:4]});
        rd(a | 8'h40, d);
        run({a, 8'h00, 16'hffff}, 32, 0, {stat(), 24'h0});
        fs <= 1'b1;
        run({a | 8'h40, 12'h5a5}, 20, 0, {stat(), resp_m[a[4:0]][15:4]});
        rd(a | 8'h40, d);
        fs <= 1'b0;
        rd(a | 8'h40, e);
        pwm <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(a | 8'h40, d);
        pwm <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk_port(flag, 1'b0);
        print_verdict();
    end
endmodule : spi_daisy_chain_frame_logic_tb
